// ===== shared/magc_defs.vh
// Purpose: constants for the microphone gain control and microphone configuration block
// Assumes: 8-bit register port, 40 MHz mclk
// Notes: RTL field positions, reset values and tick, step and settle times live here; segment and rate tables stay in the top
`ifndef MAGC_DEFS_VH
`define MAGC_DEFS_VH

`define MAGC_ADDR_MIC_CFG 8'h0B
`define MAGC_ADDR_BIAS_BTN 8'h0C
`define MAGC_ADDR_MON_FEED 8'h0D

`define MAGC_RST_MIC_CFG 8'h00
`define MAGC_RST_BIAS_BTN 8'h00
`define MAGC_RST_MON_FEED 8'h00
`define MAGC_RD_UNMAPPED 8'h00

`define MAGC_GAIN_MSB 3
`define MAGC_GAIN_LSB 0
`define MAGC_MUTE_BIT 4
`define MAGC_INT_SE_BIT 5
`define MAGC_EXT_SEL_BIT 6
`define MAGC_VGND_BIT 0
`define MAGC_BIAS_MSB 2
`define MAGC_BIAS_LSB 1
`define MAGC_BTN_TYPE_BIT 3
`define MAGC_SETTLE_MSB 5
`define MAGC_SETTLE_LSB 4
`define MAGC_MON_MSB 3
`define MAGC_MON_LSB 0

`define MAGC_MCLK_KHZ 40000
`define MAGC_TICK_MS 1
`define MAGC_STEP_BASE_MS 13'h0020
`define MAGC_SETTLE_UNIT_MS 6'h08
`define MAGC_GAIN_FLOOR 4'h0

`endif

// ===== rtl/magc_debounce.v
// Purpose: millisecond debounce of one sense level
// Assumes: msTick is a one-cycle pulse every millisecond
// Notes: settleMs of zero follows the input one cycle later
`timescale 1ns/10ps
`default_nettype none
module magc_debounce #(
  parameter CNT_W = 6
) (
  input wire mclk,
  input wire rst,
  input wire msTick,
  input wire rawIn,
  input wire [CNT_W-1:0] settleMs,
  output reg stable_r
);
  reg [CNT_W-1:0] cnt_r;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      stable_r <= 1'b0;
      cnt_r <= {CNT_W{1'b0}};
    end else if (rawIn == stable_r) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (cnt_r >= settleMs) begin
      stable_r <= rawIn;
      cnt_r <= {CNT_W{1'b0}};
    end else if (msTick) begin
      // a bounce back to the stable level restarts the wait
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/magc_top.v
// Purpose: microphone gain control with microphone and monitor-feed configuration
// Assumes: ADC samples and sense inputs synchronous to mclk
// Notes: gain control parameters arrive as plain inputs from their own registers
`timescale 1ns/10ps
`default_nettype none
`include "magc_defs.vh"
module magc_top #(
  parameter TICK_CYCLES = `MAGC_MCLK_KHZ * `MAGC_TICK_MS,
  parameter SAMPLE_W = 16
) (
  input wire mclk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire regWrEn,
  input wire [7:0] regWrData,
  input wire regRdEn,
  input wire agcEnable,
  input wire [2:0] levelGoal,
  input wire noiseGateOn,
  input wire [2:0] noiseThreshSel,
  input wire [3:0] maxGainSel,
  input wire [2:0] gainRiseStepTime,
  input wire tightTracking,
  input wire [4:0] quietSegmentCount,
  input wire [2:0] gainFallStepTime,
  input wire [2:0] segmentLengthSel,
  input wire [1:0] adcRateSel,
  input wire sampleValid,
  input wire [SAMPLE_W-1:0] sampleData,
  input wire micOpenSense,
  input wire micShortSense,
  output reg [7:0] regRdData_r,
  output reg [3:0] preampGain_r,
  output reg micSilence_r,
  output reg internalSingleEnded_r,
  output reg externalMicSelect_r,
  output reg outerBiasOut_r,
  output reg innerBiasOut_r,
  output reg [1:0] biasLevelSel_r,
  output reg virtualGroundLevel_r,
  output reg [3:0] monitorFeedLevel_r,
  output reg gateMute_r,
  output reg buttonPress_r
);
  reg [7:0] micCfg_r;
  reg [7:0] biasBtn_r;
  reg [7:0] monFeed_r;
  reg [15:0] tickCnt_r;
  reg msTick_r;
  reg [14:0] segCnt_r;
  reg [SAMPLE_W-1:0] peak_r;
  reg [4:0] quietCnt_r;
  reg riseOk_r;
  reg fallNow_r;
  reg segNoise_r;
  reg [3:0] agcGain_r;
  reg [12:0] stepMs_r;
  reg prevSign_r;
  reg prevValid_r;
  reg [1:0] dirPrev_r;

  wire [SAMPLE_W-1:0] absSample;
  wire [SAMPLE_W-1:0] minLevel;
  wire [SAMPLE_W-1:0] maxLevel;
  wire [SAMPLE_W-1:0] noiseLevel;
  wire [14:0] segLen;
  wire segEnd;
  wire zeroCross;
  wire [3:0] wantGain;
  wire [12:0] riseMs;
  wire [12:0] fallMs;
  wire [1:0] dir;
  wire stepDue;
  wire rawButton;
  wire settledButton;
  wire [5:0] settleMs;
  wire [SAMPLE_W-1:0] segPeak;

  // level tables in 16-bit full scale; approximate dB to linear
  function [15:0] goalLin;
    input [2:0] code;
    begin
      case (code)
        3'h0: goalLin = 16'h4027;
        3'h1: goalLin = 16'h32F5;
        3'h2: goalLin = 16'h287A;
        3'h3: goalLin = 16'h2027;
        3'h4: goalLin = 16'h198A;
        3'h5: goalLin = 16'h1449;
        3'h6: goalLin = 16'h101D;
        default: goalLin = 16'h0CCD;
      endcase
    end
  endfunction

  function [15:0] ceilLin;
    input tight;
    input [2:0] code;
    begin
      case ({tight, code})
        4'h0: ceilLin = 16'h5A9D;
        4'h1: ceilLin = 16'h50C3;
        4'h2: ceilLin = 16'h47FA;
        4'h3: ceilLin = 16'h4027;
        4'h4: ceilLin = 16'h392C;
        4'h5: ceilLin = 16'h32F5;
        4'h6: ceilLin = 16'h2D6B;
        4'h7: ceilLin = 16'h287A;
        4'h8: ceilLin = 16'h5A9D;
        4'h9: ceilLin = 16'h47FA;
        4'hA: ceilLin = 16'h392C;
        4'hB: ceilLin = 16'h2D6B;
        4'hC: ceilLin = 16'h2413;
        4'hD: ceilLin = 16'h1CA8;
        4'hE: ceilLin = 16'h16C3;
        default: ceilLin = 16'h1215;
      endcase
    end
  endfunction

  function [15:0] noiseLin;
    input [2:0] code;
    begin
      case (code)
        3'h0: noiseLin = 16'h0008;
        3'h1: noiseLin = 16'h0010;
        3'h2: noiseLin = 16'h0021;
        3'h3: noiseLin = 16'h0041;
        3'h4: noiseLin = 16'h0082;
        3'h5: noiseLin = 16'h0104;
        3'h6: noiseLin = 16'h0207;
        default: noiseLin = 16'h040C;
      endcase
    end
  endfunction

  function [9:0] frameMs;
    input [2:0] code;
    begin
      case (code)
        3'h0: frameMs = 10'h060;
        3'h1: frameMs = 10'h080;
        3'h2: frameMs = 10'h0C0;
        3'h3: frameMs = 10'h100;
        3'h4: frameMs = 10'h180;
        3'h5: frameMs = 10'h200;
        3'h6: frameMs = 10'h300;
        default: frameMs = 10'h3E8;
      endcase
    end
  endfunction

  function [4:0] rateKhz;
    input [1:0] code;
    begin
      case (code)
        2'h0: rateKhz = 5'h08;
        2'h1: rateKhz = 5'h0C;
        2'h2: rateKhz = 5'h10;
        default: rateKhz = 5'h18;
      endcase
    end
  endfunction

  assign absSample = sampleData[SAMPLE_W-1] ? (~sampleData + 1'b1) : sampleData;
  assign minLevel = goalLin(levelGoal);
  assign maxLevel = ceilLin(tightTracking, levelGoal);
  assign noiseLevel = noiseLin(noiseThreshSel);
  assign segLen = frameMs(segmentLengthSel) * rateKhz(adcRateSel);
  assign segEnd = sampleValid && (segCnt_r + 1'b1 >= segLen);
  assign segPeak = (absSample > peak_r) ? absSample : peak_r;
  assign zeroCross = sampleValid && prevValid_r &&
                     ((sampleData[SAMPLE_W-1] != prevSign_r) || (sampleData == {SAMPLE_W{1'b0}}));
  assign riseMs = `MAGC_STEP_BASE_MS << gainRiseStepTime;
  assign fallMs = `MAGC_STEP_BASE_MS << gainFallStepTime;
  // falling takes priority: overload is fixed before any rise resumes
  assign dir = segNoise_r ? 2'h0 : (fallNow_r ? 2'h2 : (riseOk_r ? 2'h1 : 2'h0));
  assign stepDue = msTick_r && (dir != 2'h0) && (dir == dirPrev_r) &&
                   (stepMs_r + 1'b1 >= ((dir == 2'h2) ? fallMs : riseMs));
  assign wantGain = agcEnable ? agcGain_r : micCfg_r[`MAGC_GAIN_MSB:`MAGC_GAIN_LSB];
  // code zero means no settling; the others double from the unit time
  assign settleMs = (biasBtn_r[`MAGC_SETTLE_MSB:`MAGC_SETTLE_LSB] == 2'h0) ? 6'h00 :
                    (`MAGC_SETTLE_UNIT_MS << (biasBtn_r[`MAGC_SETTLE_MSB:`MAGC_SETTLE_LSB] - 2'h1));
  // series button opens the loop, parallel one shorts it
  assign rawButton = biasBtn_r[`MAGC_BTN_TYPE_BIT] ? micOpenSense : micShortSense;

  // register port
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      micCfg_r <= `MAGC_RST_MIC_CFG;
      biasBtn_r <= `MAGC_RST_BIAS_BTN;
      monFeed_r <= `MAGC_RST_MON_FEED;
      regRdData_r <= `MAGC_RD_UNMAPPED;
    end else begin
      if (regWrEn) begin
        if (regAddr == `MAGC_ADDR_MIC_CFG) begin
          micCfg_r <= regWrData;
        end else if (regAddr == `MAGC_ADDR_BIAS_BTN) begin
          biasBtn_r <= regWrData;
        end else if (regAddr == `MAGC_ADDR_MON_FEED) begin
          monFeed_r <= regWrData;
        end
      end
      if (regRdEn) begin
        if (regAddr == `MAGC_ADDR_MIC_CFG) begin
          regRdData_r <= micCfg_r;
        end else if (regAddr == `MAGC_ADDR_BIAS_BTN) begin
          regRdData_r <= biasBtn_r;
        end else if (regAddr == `MAGC_ADDR_MON_FEED) begin
          regRdData_r <= monFeed_r;
        end else begin
          regRdData_r <= `MAGC_RD_UNMAPPED;
        end
      end
    end
  end

  // millisecond tick for step and debounce timing
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tickCnt_r <= 16'h0000;
      msTick_r <= 1'b0;
    end else if (tickCnt_r >= TICK_CYCLES[15:0] - 1'b1) begin
      tickCnt_r <= 16'h0000;
      msTick_r <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 1'b1;
      msTick_r <= 1'b0;
    end
  end

  // envelope detector and segment classing
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      segCnt_r <= 15'h0000;
      peak_r <= {SAMPLE_W{1'b0}};
      quietCnt_r <= 5'h00;
      riseOk_r <= 1'b0;
      fallNow_r <= 1'b0;
      segNoise_r <= 1'b0;
    end else if (sampleValid) begin
      if (absSample > maxLevel) begin
        fallNow_r <= 1'b1;
        // a loud sample is signal, so the fall need not wait for the segment end
        segNoise_r <= 1'b0;
      end
      if (segEnd) begin
        segCnt_r <= 15'h0000;
        peak_r <= {SAMPLE_W{1'b0}};
        if (segPeak < noiseLevel) begin
          // noise segments freeze the decision state
          segNoise_r <= 1'b1;
        end else begin
          segNoise_r <= 1'b0;
          if (segPeak > maxLevel) begin
            quietCnt_r <= 5'h00;
            riseOk_r <= 1'b0;
            fallNow_r <= 1'b1;
          end else if (segPeak < minLevel) begin
            fallNow_r <= 1'b0;
            if (quietCnt_r != 5'h1F) begin
              quietCnt_r <= quietCnt_r + 1'b1;
            end
            riseOk_r <= (quietCnt_r >= quietSegmentCount);
          end else begin
            quietCnt_r <= 5'h00;
            riseOk_r <= 1'b0;
            fallNow_r <= 1'b0;
          end
        end
      end else begin
        segCnt_r <= segCnt_r + 1'b1;
        peak_r <= segPeak;
      end
    end
  end

  // automatic gain stepping
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      agcGain_r <= `MAGC_GAIN_FLOOR;
      stepMs_r <= 13'h0000;
      dirPrev_r <= 2'h0;
    end else begin
      dirPrev_r <= dir;
      if (!agcEnable) begin
        // start from the manual setting when control is switched on
        agcGain_r <= micCfg_r[`MAGC_GAIN_MSB:`MAGC_GAIN_LSB];
        stepMs_r <= 13'h0000;
      end else if (agcGain_r > maxGainSel) begin
        agcGain_r <= maxGainSel;
      end else if (dir != dirPrev_r || dir == 2'h0) begin
        stepMs_r <= 13'h0000;
      end else if (stepDue) begin
        stepMs_r <= 13'h0000;
        // wait until the last step is on the amplifier before the next
        if (preampGain_r == agcGain_r) begin
          if (dir == 2'h2 && agcGain_r != `MAGC_GAIN_FLOOR) begin
            agcGain_r <= agcGain_r - 1'b1;
          end else if (dir == 2'h1 && agcGain_r < maxGainSel) begin
            agcGain_r <= agcGain_r + 1'b1;
          end
        end
      end else if (msTick_r) begin
        stepMs_r <= stepMs_r + 1'b1;
      end
    end
  end

  // gain applied only as the waveform crosses zero; a zero sample also counts as a crossing
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      preampGain_r <= `MAGC_GAIN_FLOOR;
      prevSign_r <= 1'b0;
      prevValid_r <= 1'b0;
      gateMute_r <= 1'b0;
    end else begin
      if (sampleValid) begin
        prevSign_r <= sampleData[SAMPLE_W-1];
        prevValid_r <= 1'b1;
      end
      if (zeroCross && preampGain_r != wantGain) begin
        preampGain_r <= wantGain;
      end
      // gate only the output; the loop already holds on noise segments, gated or not
      gateMute_r <= noiseGateOn && segNoise_r;
    end
  end

  // configuration pins
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      micSilence_r <= 1'b0;
      internalSingleEnded_r <= 1'b0;
      externalMicSelect_r <= 1'b0;
      outerBiasOut_r <= 1'b0;
      innerBiasOut_r <= 1'b0;
      biasLevelSel_r <= 2'h0;
      virtualGroundLevel_r <= 1'b0;
      monitorFeedLevel_r <= 4'h0;
      buttonPress_r <= 1'b0;
    end else begin
      micSilence_r <= micCfg_r[`MAGC_MUTE_BIT];
      internalSingleEnded_r <= micCfg_r[`MAGC_INT_SE_BIT];
      externalMicSelect_r <= micCfg_r[`MAGC_EXT_SEL_BIT];
      outerBiasOut_r <= micCfg_r[`MAGC_EXT_SEL_BIT];
      innerBiasOut_r <= ~micCfg_r[`MAGC_EXT_SEL_BIT];
      biasLevelSel_r <= biasBtn_r[`MAGC_BIAS_MSB:`MAGC_BIAS_LSB];
      virtualGroundLevel_r <= biasBtn_r[`MAGC_VGND_BIT];
      monitorFeedLevel_r <= monFeed_r[`MAGC_MON_MSB:`MAGC_MON_LSB];
      // series button needs no settling, parallel one bounces on the short
      buttonPress_r <= biasBtn_r[`MAGC_BTN_TYPE_BIT] ? micOpenSense : settledButton;
    end
  end

  magc_debounce #(
    .CNT_W(6)
  ) uButtonSettle (
    .mclk(mclk),
    .rst(rst),
    .msTick(msTick_r),
    .rawIn(rawButton),
    .settleMs(settleMs),
    .stable_r(settledButton)
  );
endmodule
`default_nettype wire

// ===== tb/magc_top_asserts.sv
// Purpose: port checker for the microphone gain and configuration block
// Assumes: one clock, async active-high reset
// Notes: config outputs checked three edges after a write to cover either output latency
`timescale 1ns/10ps
`default_nettype none
module magc_top_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic sampleValid,
  input wire logic noiseGateOn,
  input wire logic micOpenSense,
  input wire logic [7:0] regRdData_r,
  input wire logic [3:0] preampGain_r,
  input wire logic micSilence_r,
  input wire logic externalMicSelect_r,
  input wire logic outerBiasOut_r,
  input wire logic innerBiasOut_r,
  input wire logic [1:0] biasLevelSel_r,
  input wire logic virtualGroundLevel_r,
  input wire logic [3:0] monitorFeedLevel_r,
  input wire logic gateMute_r,
  input wire logic buttonPress_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic serType_r;
  logic [2:0] serSh_r;
  // shadow of the button type bit, aged so mode switches are not judged
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      serType_r <= 1'b0;
      serSh_r <= 3'h0;
    end else begin
      if (regWrEn && regAddr == 8'h0B + 8'h01) begin
        serType_r <= regWrData[3];
      end
      serSh_r <= {serSh_r[1:0], serType_r};
    end
  end
  a_gain_cross: assert property ($changed(preampGain_r) |-> $past(sampleValid))
    else $error("gain moved without a sample");
  a_mute_follow: assert property (regWrEn && regAddr == 8'h0B |-> ##3
    micSilence_r == $past(regWrData[4], 3) && externalMicSelect_r == $past(regWrData[6], 3))
    else $error("mic config output wrong");
  a_bias_pair: assert property (!$past(rst) |->
    innerBiasOut_r != outerBiasOut_r && outerBiasOut_r == externalMicSelect_r)
    else $error("bias outputs wrong");
  a_rd_unmap: assert property (regRdEn && (regAddr < 8'h0B || regAddr > 8'h0D) |=> regRdData_r == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!regRdEn |=> $stable(regRdData_r))
    else $error("read data moved");
  a_bias_sel: assert property (regWrEn && regAddr == 8'h0C |-> ##3
    {biasLevelSel_r, virtualGroundLevel_r} == $past(regWrData[2:0], 3))
    else $error("bias select wrong");
  a_mon_feed: assert property (regWrEn && regAddr == 8'h0D |-> ##3
    monitorFeedLevel_r == $past(regWrData[3:0], 3))
    else $error("monitor level wrong");
  a_series_btn: assert property (serSh_r == 3'h7 |-> buttonPress_r == $past(micOpenSense))
    else $error("series button wrong");
  a_gate_off: assert property (!noiseGateOn [*2] |-> !gateMute_r)
    else $error("gate muting while off");
endmodule
`default_nettype wire

// ===== tb/magc_adc_model.sv
// Purpose: ADC sample stream feeding the gain control
// Assumes: one sample every four clocks
// Notes: sign flips each sample, so every sample after the first is a zero crossing
`timescale 1ns/10ps
`default_nettype none
module magc_adc_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] amp,
  output logic sampleValid,
  output logic [15:0] sampleData
);
  logic [1:0] divCnt;
  logic negHalf;
  always @(negedge mclk or posedge rst) begin
    if (rst) begin
      divCnt <= 2'h0;
      negHalf <= 1'b0;
      sampleValid <= 1'b0;
      sampleData <= 16'h0000;
    end else begin
      divCnt <= divCnt + 2'h1;
      sampleValid <= (divCnt == 2'h3);
      if (divCnt == 2'h3) begin
        negHalf <= ~negHalf;
        sampleData <= negHalf ? 16'h0000 - amp : amp; // no dc offset, as with the high-pass on
      end else begin
        // data invalid between samples, so never left looking valid
        sampleData <= ~sampleData;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_mic_agc_and_mic_config.sv
// Purpose: self-checking bench for the microphone gain and configuration block
// Assumes: TICK_CYCLES shortened to 4
// Notes: gain-control timing checked by step direction, limits and one early fall-step check only
`timescale 1ns/10ps
`default_nettype none
module test_mic_agc_and_mic_config;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [11:0] v;} magc_row_t;
  logic mclk, rst, regWrEn, regRdEn, agcEnable, noiseGateOn, micOpenSense, micShortSense;
  logic tightTracking, sampleValid, micSilence_r, internalSingleEnded_r, externalMicSelect_r;
  logic outerBiasOut_r, innerBiasOut_r, virtualGroundLevel_r, gateMute_r, buttonPress_r;
  logic [7:0] regAddr, regWrData, regRdData_r;
  logic [15:0] amp, sampleData;
  logic [3:0] preampGain_r, monitorFeedLevel_r, maxGainSel, gExp;
  logic [2:0] levelGoal, noiseThreshSel, gainFallStepTime;
  logic [4:0] quietSegmentCount;
  logic [1:0] biasLevelSel_r;
  logic [11:0] cfgVec;
  int badCount, cmpCount, cyc;
  // external mic chosen while muted, monitor feed raised to 1 then F meanwhile
  magc_row_t rows [8] = '{'{8'h0B, 8'h7A, 12'hF00}, '{8'h0C, 8'h07, 12'hF70}, '{8'h0D, 8'h01, 12'hF71},
    '{8'h0D, 8'h0F, 12'hF7F}, '{8'h0B, 8'h05, 12'h0FF}, '{8'h0C, 8'h02, 12'h0AF},
    '{8'h0C, 8'h34, 12'h0CF}, '{8'h0E, 8'hFF, 12'h0CF}};
  assign cfgVec = {micSilence_r, internalSingleEnded_r, externalMicSelect_r, outerBiasOut_r,
    innerBiasOut_r, biasLevelSel_r, virtualGroundLevel_r, monitorFeedLevel_r};
  magc_top #(.TICK_CYCLES(4)) magc_top_inst (.mclk, .rst, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .agcEnable, .levelGoal, .noiseGateOn, .noiseThreshSel, .maxGainSel, .gainRiseStepTime(3'h0),
    .tightTracking, .quietSegmentCount, .gainFallStepTime, .segmentLengthSel(3'h0),
    .adcRateSel(2'h0), .sampleValid, .sampleData, .micOpenSense, .micShortSense, .regRdData_r,
    .preampGain_r, .micSilence_r, .internalSingleEnded_r, .externalMicSelect_r, .outerBiasOut_r,
    .innerBiasOut_r, .biasLevelSel_r, .virtualGroundLevel_r, .monitorFeedLevel_r, .gateMute_r, .buttonPress_r);
  magc_adc_model magc_adc_model_inst (.mclk, .rst, .amp, .sampleValid, .sampleData);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reportAndStop;
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge mclk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge mclk);
    regRdEn = 1'b0;
    chk(regRdData_r, exp);
  endtask
  // waits for the next gain change, bounded; no change leaves the old gain
  task automatic step(input logic [3:0] exp, input int lim);
    logic [3:0] g;
    int n;
    g = preampGain_r;
    n = 0;
    while (preampGain_r === g && n < lim) begin
      @(negedge mclk);
      n++;
    end
    chk(preampGain_r, exp);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      badCount++;
      $display("timeout at %0t", $time);
      reportAndStop;
    end
  end
  initial begin
    rst = 1'b1;
    {regWrEn, regRdEn, agcEnable, noiseGateOn, micOpenSense, micShortSense, tightTracking} = 7'h00;
    regAddr = 8'h00;
    regWrData = 8'h00;
    amp = 16'h0040;
    levelGoal = 3'h0;
    noiseThreshSel = 3'h0;
    gainFallStepTime = 3'h0;
    maxGainSel = 4'hA;
    quietSegmentCount = 5'h01;
    gExp = 4'h0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      if (rows[i].a == 8'h0B) gExp = rows[i].d[3:0];
      repeat (12) @(negedge mclk);
      chk(cfgVec, rows[i].v); // pins follow fields
      chk(preampGain_r, gExp); // manual gain at a crossing
      rd(rows[i].a, rows[i].a == 8'h0E ? 8'h00 : rows[i].d);
    end
    wr(8'h0C, 8'h08);
    micOpenSense = 1'b1;
    repeat (3) @(negedge mclk);
    chk(buttonPress_r, 1'b1); // series press
    micOpenSense = 1'b0;
    micShortSense = 1'b1;
    repeat (3) @(negedge mclk);
    chk(buttonPress_r, 1'b0); // short ignored in series mode
    wr(8'h0C, 8'h10);
    repeat (20) @(negedge mclk);
    chk(buttonPress_r, 1'b0); // still settling
    repeat (30) @(negedge mclk);
    chk(buttonPress_r, 1'b1); // settled after 8 ms
    micShortSense = 1'b0;
    agcEnable = 1'b1;
    for (int k = 6; k <= 10; k++) step(k[3:0], 20000); // quiet rise
    step(4'hA, 4000); // held at max gain
    // mic heard through the mixer
    tightTracking = 1'b1;
    gainFallStepTime = 3'h1;
    amp = 16'h7F00;
    step(4'h9, 1000); // loud drop after one 64 ms fall step, before the segment ends
    repeat (200) @(negedge mclk);
    chk(preampGain_r, 4'h9); // 64 ms fall step not yet due
    // slow fall so the gain is still off the floor when noise starts
    gainFallStepTime = 3'h4;
    noiseThreshSel = 3'h7;
    amp = 16'h0100;
    noiseGateOn = 1'b1;
    for (int n = 0; n < 10000 && gateMute_r !== 1'b1; n++) @(negedge mclk);
    chk(gateMute_r, 1'b1); // hum under threshold gated
    repeat (8) @(negedge mclk);
    gExp = preampGain_r;
    repeat (2500) @(negedge mclk);
    chk(preampGain_r, gExp); // noise leaves gain
    noiseGateOn = 1'b0;
    repeat (3) @(negedge mclk);
    chk(gateMute_r, 1'b0);
    rst = 1'b1;
    @(negedge mclk);
    chk({cfgVec, preampGain_r}, 16'h0000);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk(cfgVec, 12'h080); // internal mic bias after reset
    rd(8'h0B, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h0D, 8'h00);
    reportAndStop;
  end
endmodule
bind magc_top magc_top_asserts magc_top_asserts_inst (.mclk, .rst, .regAddr, .regWrEn, .regWrData,
  .regRdEn, .sampleValid, .noiseGateOn, .micOpenSense, .regRdData_r, .preampGain_r, .micSilence_r,
  .externalMicSelect_r, .outerBiasOut_r, .innerBiasOut_r, .biasLevelSel_r, .virtualGroundLevel_r,
  .monitorFeedLevel_r, .gateMute_r, .buttonPress_r);
`default_nettype wire
